//--- cft_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module cft_bus_model (
  input wire logic drive_in,
  input wire logic other_node_in,
  output logic bus_dominant_out
);
  // Dominant from any node wins on the wire
  assign bus_dominant_out = drive_in | other_node_in;
endmodule
`default_nettype wire

//--- cft_dom_timer.sv
`timescale 1ns/100ps
`default_nettype none
module cft_dom_timer #(
  parameter logic [19:0] TIMEOUT = cft_pkg::DOM_TIMEOUT_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic tx_in,
  output logic expired_out
);
  logic [cft_pkg::CNT_W-1:0] cnt_q;
  logic tx_prev_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_prev_q <= cft_pkg::TX_IDLE_RESET;
    end else begin
      tx_prev_q <= tx_in;
    end
  end

  // Counts while low since falling edge, stopping at TIMEOUT; any high cycle clears
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_q <= cft_pkg::CNT_RESET;
      expired_out <= 1'b0;
    end else if (tx_in) begin
      cnt_q <= cft_pkg::CNT_RESET;
      expired_out <= 1'b0;
    end else if (tx_prev_q && !tx_in) begin
      cnt_q <= 20'h00001;
    end else if (cnt_q >= TIMEOUT) begin
      expired_out <= 1'b1;
    end else if (cnt_q != cft_pkg::CNT_RESET) begin
      cnt_q <= cnt_q + 20'h00001;
    end
  end

  chk_timer_clears: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) tx_in |=> !expired_out)
    else $error("timer not cleared on high");
endmodule
`default_nettype wire

//--- cft_pkg.sv
package cft_pkg;
  // Dominant-timeout length in clock cycles
  localparam int unsigned DOM_TIMEOUT_CYCLES = 100000;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
  localparam logic [19:0] DOM_TIMEOUT_DEFAULT = 20'h186A0;
  localparam logic TX_IDLE_RESET = 1'b1;

  typedef enum logic [2:0] {
    CFT_ST_OFF = 3'b001,
    CFT_ST_RUN = 3'b010,
    CFT_ST_HOLD = 3'b100
  } cft_state_type;
endpackage

//--- cft_transceiver.sv
`timescale 1ns/100ps
`default_nettype none
module cft_transceiver #(
  parameter logic [19:0] DOM_TIMEOUT = cft_pkg::DOM_TIMEOUT_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic tx_data_in,
  input wire logic tx_data_driven_in,
  input wire logic silent_sel_in,
  input wire logic silent_sel_driven_in,
  input wire logic core_supply_ok_in,
  input wire logic io_supply_ok_in,
  input wire logic over_temp_in,
  input wire logic bus_dominant_in,
  output logic rx_data_out,
  output logic bus_drive_dominant_out,
  output logic bus_bias_en_out,
  output logic silent_mode_out,
  output logic thermal_off_out
);
  cft_pkg::cft_state_type state_q;
  cft_pkg::cft_state_type state_d;
  logic tx_eff;
  logic silent_eff;
  logic supplies_ok;
  logic dom_expired;
  logic therm_q;
  logic drive_d;

  assign tx_eff = tx_data_driven_in ? tx_data_in : 1'b1;
  assign silent_eff = silent_sel_driven_in ? silent_sel_in : 1'b1;
  assign supplies_ok = core_supply_ok_in && io_supply_ok_in;

  cft_dom_timer #(.TIMEOUT(DOM_TIMEOUT)) u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in || !supplies_ok),
    .tx_in(tx_eff),
    .expired_out(dom_expired)
  );

  // OFF: unpowered; HOLD: waiting for transmit high; RUN: active
  always_comb begin
    state_d = state_q;
    case (state_q)
      cft_pkg::CFT_ST_OFF: begin
        if (supplies_ok) begin
          state_d = cft_pkg::CFT_ST_HOLD;
        end
      end
      cft_pkg::CFT_ST_HOLD: begin
        if (tx_eff) begin
          state_d = cft_pkg::CFT_ST_RUN;
        end
      end
      cft_pkg::CFT_ST_RUN: begin
        state_d = cft_pkg::CFT_ST_RUN;
      end
      default: begin
        state_d = cft_pkg::CFT_ST_OFF;
      end
    endcase
    if (!supplies_ok) begin
      state_d = cft_pkg::CFT_ST_OFF;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= cft_pkg::CFT_ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !supplies_ok) begin
      therm_q <= 1'b0;
    end else if (over_temp_in) begin
      therm_q <= 1'b1;
    end else if (tx_eff) begin
      therm_q <= 1'b0;
    end
  end

  always_comb begin
    drive_d = (state_q == cft_pkg::CFT_ST_RUN) && !tx_eff
      && !silent_eff
      && !therm_q && !over_temp_in
      && !dom_expired;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bus_drive_dominant_out <= 1'b0;
      bus_bias_en_out <= 1'b0;
      rx_data_out <= 1'b1;
      silent_mode_out <= 1'b1;
      thermal_off_out <= 1'b0;
    end else begin
      bus_drive_dominant_out <= drive_d && supplies_ok;
      bus_bias_en_out <= supplies_ok && (state_q != cft_pkg::CFT_ST_OFF);
      rx_data_out <= !(bus_dominant_in && supplies_ok);
      silent_mode_out <= silent_eff;
      thermal_off_out <= therm_q || over_temp_in;
    end
  end

  // Mode checks
  chk_silent_recessive: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) silent_eff |=> !bus_drive_dominant_out)
    else $error("dominant in silent mode");

  chk_silent_flag: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) 1'b1 |=> silent_mode_out == $past(silent_eff))
    else $error("silent flag wrong");

  chk_normal_dominant: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (state_q == cft_pkg::CFT_ST_RUN && !silent_eff
    && !tx_eff && !therm_q && !over_temp_in && !dom_expired && supplies_ok)
    |=> bus_drive_dominant_out) else $error("normal mode not driving");

  chk_high_recessive: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) tx_eff |=> !bus_drive_dominant_out)
    else $error("dominant with transmit high");

  // Receive path checks
  chk_rx_follows: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) supplies_ok |=> rx_data_out == !$past(bus_dominant_in))
    else $error("receive output wrong");

  chk_rx_dominant: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (supplies_ok && bus_dominant_in) |=> !rx_data_out)
    else $error("receive not low on dominant");

  // Power-off, state-code and bias checks
  chk_uv_float: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) !supplies_ok |=> !bus_drive_dominant_out
    && !bus_bias_en_out && state_q == cft_pkg::CFT_ST_OFF)
    else $error("not off on undervoltage");

  chk_off_rx_high: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) !supplies_ok |=> rx_data_out)
    else $error("receive low while unpowered");

  chk_off_no_thermal: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) !supplies_ok |=> !therm_q)
    else $error("thermal kept through power-off");

  chk_off_bias_low: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) state_q == cft_pkg::CFT_ST_OFF |=> !bus_bias_en_out)
    else $error("bus biased while off");

  chk_recover_hold: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (state_q == cft_pkg::CFT_ST_OFF && supplies_ok)
    |=> state_q == cft_pkg::CFT_ST_HOLD) else $error("no recovery");

  chk_state_onehot: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) $onehot(state_q))
    else $error("state code not one-hot");

  chk_run_bias: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (state_q == cft_pkg::CFT_ST_RUN && supplies_ok)
    |=> bus_bias_en_out) else $error("bus not biased when running");

  // Release after power-off
  chk_hold_nodrive: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) state_q == cft_pkg::CFT_ST_HOLD
    |=> !bus_drive_dominant_out) else $error("dominant before release");

  chk_hold_to_run: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (state_q == cft_pkg::CFT_ST_HOLD && tx_eff
    && supplies_ok) |=> state_q == cft_pkg::CFT_ST_RUN)
    else $error("release not taken");

  chk_drive_only_run: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) state_q != cft_pkg::CFT_ST_RUN
    |=> !bus_drive_dominant_out) else $error("dominant outside run");

  // Thermal checks
  chk_thermal_off: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) over_temp_in |=> !bus_drive_dominant_out
    ##0 thermal_off_out) else $error("thermal not off");

  chk_thermal_set: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (over_temp_in && supplies_ok) |=> therm_q)
    else $error("thermal flag not set");

  chk_thermal_rx: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (over_temp_in && supplies_ok)
    |=> rx_data_out == !$past(bus_dominant_in))
    else $error("receive stopped while hot");

  chk_thermal_hold: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (therm_q && !tx_eff && supplies_ok) |=> therm_q)
    else $error("thermal cleared early");

  chk_thermal_clear: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) (therm_q && tx_eff && !over_temp_in)
    |=> !therm_q) else $error("thermal not cleared");

  // Timeout and pull-up checks
  chk_timeout_off: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) dom_expired |=> !bus_drive_dominant_out)
    else $error("dominant after timeout");

  chk_pullup_tx: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) !tx_data_driven_in |=> !bus_drive_dominant_out)
    else $error("undriven transmit gave dominant");

  chk_pullup_mode: assert property (@(posedge ref_clk_in)
    disable iff (rst_in) !silent_sel_driven_in |=> silent_mode_out)
    else $error("undriven mode not silent");
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tx = 1'b1, tx_drv = 1'b1, sil = 1'b0, sil_drv = 1'b1;
  logic core_ok = 1'b0, io_ok = 1'b0, hot = 1'b0, other = 1'b0;
  logic bus_dom, rx, drv, bias, sil_m, th_off;
  int miscompares = 0;
  int checked = 0;
  always #20 clk = ~clk;
  cft_transceiver #(.DOM_TIMEOUT(20'h00014)) DUT (.ref_clk_in(clk),
    .rst_in(rst), .tx_data_in(tx), .tx_data_driven_in(tx_drv),
    .silent_sel_in(sil), .silent_sel_driven_in(sil_drv),
    .core_supply_ok_in(core_ok), .io_supply_ok_in(io_ok),
    .over_temp_in(hot), .bus_dominant_in(bus_dom), .rx_data_out(rx),
    .bus_drive_dominant_out(drv), .bus_bias_en_out(bias),
    .silent_mode_out(sil_m), .thermal_off_out(th_off));
  cft_bus_model bus (.drive_in(drv), .other_node_in(other),
    .bus_dominant_out(bus_dom));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Controller side: low runs stay short of the timeout, except the 30-clock low run in t_timeout
  task send(input logic v, input int n);
    tx = v;
    step(n);
  endtask
  // Order: rx, drive, bias, silent, thermal
  task check(input logic [4:0] exp, input logic [4:0] m = 5'h1F);
    checked++;
    if (({rx, drv, bias, sil_m, th_off} & m) !== (exp & m)) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time,
        {rx, drv, bias, sil_m, th_off}, exp);
    end
  endtask
  task conclude;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task t_normal;
    send(1'b0, 3);
    check(5'h0C);
    send(1'b1, 3);
    check(5'h14);
  endtask
  task t_silent;
    sil = 1'b1;
    send(1'b0, 3);
    check(5'h16);
    sil = 1'b0;
    send(1'b1, 3);
  endtask
  task t_timeout;
    send(1'b0, 15);
    check(5'h0C);
    step(15);
    check(5'h14);
    send(1'b1, 2);
    send(1'b0, 3);
    check(5'h0C);
    send(1'b1, 3);
  endtask
  task t_thermal;
    hot = 1'b1;
    other = 1'b1;
    send(1'b0, 3);
    check(5'h05);
    hot = 1'b0;
    other = 1'b0;
    step(3);
    check(5'h15);
    send(1'b1, 3);
    check(5'h14);
    send(1'b0, 3);
    check(5'h0C);
    send(1'b1, 3);
  endtask
  task t_supply(input logic c);
    core_ok = ~c;
    io_ok = c;
    send(1'b0, 3);
    check(5'h10, 5'h1D);
    core_ok = 1'b1;
    io_ok = 1'b1;
    step(5);
    check(5'h14);
    send(1'b1, 3);
    send(1'b0, 3);
    check(5'h0C);
    send(1'b1, 3);
  endtask
  // Fastest data phase: five clocks a bit
  task t_fast;
    int k;
    for (k = 0; k < 4; k++) begin
      send(1'b0, 5);
      check(5'h0C);
      send(1'b1, 5);
      check(5'h14);
    end
  endtask
  task t_pullup;
    tx_drv = 1'b0;
    send(1'b0, 3);
    check(5'h14);
    sil_drv = 1'b0;
    step(3);
    check(5'h16);
    tx_drv = 1'b1;
    sil_drv = 1'b1;
    send(1'b1, 3);
  endtask
  initial begin
    int i;
    step(12);
    check(5'h12);
    rst = 1'b0;
    core_ok = 1'b1;
    io_ok = 1'b1;
    for (i = 0; i < 10 && bias !== 1'b1; i++) step(1);
    if (bias !== 1'b1) begin
      miscompares++;
      conclude();
    end
    step(2);
    t_normal();
    t_fast();
    t_silent();
    t_timeout();
    t_thermal();
    t_supply(1'b0);
    t_supply(1'b1);
    t_pullup();
    conclude();
  end
endmodule
`default_nettype wire
